/* hw/tap_pkg.sv */
// Purpose: constants and carrier types for the boundary-scan test port
// Assumes: one system clock sampling the test pins
// Notes:   instruction codes are three bits, eight codes, three reserved
package tap_pkg;

  localparam int          INSTR_W     = 3;
  localparam int          IDCODE_W    = 32;
  localparam int          BSR_LEN     = 110;
  localparam int          BSR_OE_BIT  = 109;
  localparam int          NUM_PINS    = 109;
  localparam int          RESET_TMS_N = 5;

  localparam logic [2:0]  INS_EXTEST  = 3'h0;
  localparam logic [2:0]  INS_IDCODE  = 3'h1;
  localparam logic [2:0]  INS_SAMPLEZ = 3'h2;
  localparam logic [2:0]  INS_SAMPLE  = 3'h4;
  localparam logic [2:0]  INS_BYPASS  = 3'h7;
  localparam logic [1:0]  IR_CAPTURE  = 2'h1;

  // revision 000, part configuration all zero, vendor field arbitrary, start bit 1
  localparam logic [2:0]  ID_REV      = 3'h0;
  localparam logic [16:0] ID_PART     = 17'h00000;
  localparam logic [10:0] ID_VENDOR   = 11'h2a5;
  localparam logic [31:0] ID_WORD     = {ID_REV, ID_PART, ID_VENDOR, 1'b1};

  typedef enum logic [15:0] {
    ST_RESET      = 16'h0001,
    ST_IDLE       = 16'h0002,
    ST_SEL_DR     = 16'h0004,
    ST_CAP_DR     = 16'h0008,
    ST_SHIFT_DR   = 16'h0010,
    ST_EXIT1_DR   = 16'h0020,
    ST_PAUSE_DR   = 16'h0040,
    ST_EXIT2_DR   = 16'h0080,
    ST_UPD_DR     = 16'h0100,
    ST_SEL_IR     = 16'h0200,
    ST_CAP_IR     = 16'h0400,
    ST_SHIFT_IR   = 16'h0800,
    ST_EXIT1_IR   = 16'h1000,
    ST_PAUSE_IR   = 16'h2000,
    ST_EXIT2_IR   = 16'h4000,
    ST_UPD_IR     = 16'h8000
  } tap_state_t;

  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } tap_pins_t;

  typedef struct packed {
    logic tdo;
    logic tdo_oe_n;
  } tap_out_t;

endpackage : tap_pkg

/* hw/pin_sync.sv */
// Purpose: two-flop synchroniser for a group of test pins
// Assumes: pins are asynchronous to clk
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ns
module pin_sync #(
  parameter int W = 3
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // pins
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_sync_ff
);

  logic [W-1:0] meta_ff;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      meta_ff     <= '0;
      pin_sync_ff <= '0;
    end else begin
      meta_ff     <= pin_in;
      pin_sync_ff <= meta_ff;
    end
  end

endmodule : pin_sync

/* hw/scan_cell.sv */
// Purpose: one boundary-scan cell with capture/shift stage and update latch
// Assumes: enables are one-cycle pulses on clk
// Notes:   update stage resets to zero
`timescale 1ns/1ns
module scan_cell (
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  input  wire logic tap_rst,
  // controls
  input  wire logic capture_en,
  input  wire logic shift_en,
  input  wire logic update_en,
  // data
  input  wire logic pin_val,
  input  wire logic scan_in,
  output logic      shift_ff,
  output logic      upd_ff
);

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shift_ff <= 1'b0;
    end else if (capture_en) begin
      shift_ff <= pin_val;
    end else if (shift_en) begin
      shift_ff <= scan_in;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || tap_rst) begin
      upd_ff <= 1'b0;
    end else if (update_en) begin
      upd_ff <= shift_ff;
    end
  end

endmodule : scan_cell

/* hw/sram_boundary_scan_tap.sv */
// Purpose: boundary-scan test access port of a synchronous memory
// Assumes: clk far faster than the test clock; pins enter via two flops
// Notes:   memory datapath is outside; only pin snapshots and overrides here
// Operation
// - sample inputs at test-clock rise, change test outputs at its fall
// - serial input feeds register MSB, output taken from its LSB
// - power-up resets the port so serial output starts high impedance
// - five rising edges with mode-select high return to test-logic-reset
// - test-port reset never disturbs normal memory operation
// - only one register sits between serial input and output at a time
// - three-bit instruction register loaded at update-IR
// - instruction register preset to identification read at reset
// - capture-IR loads binary 01 into the two low shift bits
// - single-bit bypass register, cleared when bypass instruction runs
// - boundary register: one cell per ball, captures pins, shifts
// - identification instruction captures and shifts a fixed 32-bit word
// - new instruction acts only after update-IR
// - sample-with-tristate shifts boundary register and floats output bus
// - sample/preload shifts boundary register and snapshots all balls
// - preload moves shifted pattern into the latched cell outputs
// - new preload shifts in while captured sample shifts out
// - bypass plus shift-DR routes serial input through bypass bit
// - external test drives preloaded values onto output pins
// - cell 109 enables output bus in external test, low after reset
`timescale 1ns/1ns
module sram_boundary_scan_tap
  import tap_pkg::*;
(
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  // test pins
  input  wire tap_pkg::tap_pins_t            tap_pins,
  output tap_pkg::tap_out_t                  tap_out,
  // memory ball ring
  input  wire logic [tap_pkg::NUM_PINS-1:0]  ball_in,
  output logic      [tap_pkg::NUM_PINS-1:0]  ball_test_ff,
  output logic                               ball_test_sel_ff,
  output logic                               qbus_hiz_ff
);
  import tap_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers and test-clock edges

  logic [2:0]        pins_sync;
  logic              tck_s;
  logic              tms_s;
  logic              tdi_s;
  logic              tck_d_ff;
  logic              tck_rise;
  logic              tck_fall;

  pin_sync #(.W(3)) u_sync (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .pin_in      ({tap_pins.tck, tap_pins.tms, tap_pins.tdi}),
    .pin_sync_ff (pins_sync)
  );

  assign tck_s = pins_sync[2];
  assign tms_s = pins_sync[1];
  assign tdi_s = pins_sync[0];

  logic [NUM_PINS-1:0] ball_s;

  // balls are asynchronous to clk, so capture reads them after two flops
  pin_sync #(.W(NUM_PINS)) u_ball_sync (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .pin_in      (ball_in),
    .pin_sync_ff (ball_s)
  );

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tck_d_ff <= 1'b0;
    end else begin
      tck_d_ff <= tck_s;
    end
  end

  assign tck_rise = tck_s & ~tck_d_ff;
  assign tck_fall = ~tck_s & tck_d_ff;

  ////////////////////////////////////////////////////////////////////////
  // controller state machine

  tap_state_t state_ff;
  tap_state_t nxt_state;

  always_comb begin
    case (state_ff)
      ST_RESET:    nxt_state = tms_s ? ST_RESET    : ST_IDLE;
      ST_IDLE:     nxt_state = tms_s ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_DR:   nxt_state = tms_s ? ST_SEL_IR   : ST_CAP_DR;
      ST_CAP_DR:   nxt_state = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR: nxt_state = tms_s ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR: nxt_state = tms_s ? ST_UPD_DR   : ST_PAUSE_DR;
      ST_PAUSE_DR: nxt_state = tms_s ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR: nxt_state = tms_s ? ST_UPD_DR   : ST_SHIFT_DR;
      ST_UPD_DR:   nxt_state = tms_s ? ST_SEL_DR   : ST_IDLE;
      ST_SEL_IR:   nxt_state = tms_s ? ST_RESET    : ST_CAP_IR;
      ST_CAP_IR:   nxt_state = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR: nxt_state = tms_s ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR: nxt_state = tms_s ? ST_UPD_IR   : ST_PAUSE_IR;
      ST_PAUSE_IR: nxt_state = tms_s ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR: nxt_state = tms_s ? ST_UPD_IR   : ST_SHIFT_IR;
      ST_UPD_IR:   nxt_state = tms_s ? ST_SEL_DR   : ST_IDLE;
      default:     nxt_state = ST_RESET;
    endcase
  end

  // tms-high walk reaches reset in five edges by state table
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_ff <= ST_RESET;
    end else if (tck_rise) begin
      state_ff <= nxt_state;
    end
  end

  logic in_reset;
  logic cap_dr;
  logic sh_dr;
  logic upd_dr;
  logic cap_ir;
  logic sh_ir;
  logic upd_ir;

  assign in_reset = (state_ff == ST_RESET);
  assign cap_dr   = tck_rise && (state_ff == ST_CAP_DR);
  assign sh_dr    = tck_rise && (state_ff == ST_SHIFT_DR);
  assign upd_dr   = tck_rise && (state_ff == ST_UPD_DR);
  assign cap_ir   = tck_rise && (state_ff == ST_CAP_IR);
  assign sh_ir    = tck_rise && (state_ff == ST_SHIFT_IR);
  assign upd_ir   = tck_rise && (state_ff == ST_UPD_IR);

  ////////////////////////////////////////////////////////////////////////
  // instruction register

  logic [INSTR_W-1:0] ir_shift_ff;
  logic [INSTR_W-1:0] ir_ff;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ir_shift_ff <= INS_IDCODE;
    end else if (cap_ir) begin
      ir_shift_ff <= {ir_ff[INSTR_W-1:2], IR_CAPTURE};
    end else if (sh_ir) begin
      ir_shift_ff <= {tdi_s, ir_shift_ff[INSTR_W-1:1]};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst || in_reset) begin
      ir_ff <= INS_IDCODE;
    end else if (upd_ir) begin
      ir_ff <= ir_shift_ff;
    end
  end

  logic sel_bsr;
  logic sel_id;

  assign sel_bsr = (ir_ff == INS_EXTEST) || (ir_ff == INS_SAMPLEZ) ||
                   (ir_ff == INS_SAMPLE);
  assign sel_id  = (ir_ff == INS_IDCODE);

  ////////////////////////////////////////////////////////////////////////
  // bypass and identification registers

  logic              bypass_ff;
  logic [IDCODE_W-1:0] id_shift_ff;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bypass_ff <= 1'b0;
    end else if (cap_dr && !sel_bsr && !sel_id) begin
      bypass_ff <= 1'b0;
    end else if (sh_dr && !sel_bsr && !sel_id) begin
      bypass_ff <= tdi_s;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      id_shift_ff <= '0;
    end else if (cap_dr && sel_id) begin
      id_shift_ff <= ID_WORD;
    end else if (sh_dr && sel_id) begin
      id_shift_ff <= {tdi_s, id_shift_ff[IDCODE_W-1:1]};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // boundary scan register

  logic [BSR_LEN-1:0] bsr_shift;
  logic [BSR_LEN-1:0] bsr_upd;
  logic [BSR_LEN-1:0] bsr_pin;
  logic [BSR_LEN-1:0] bsr_sin;

  // cell 109 captures the live enable, ring cells the balls
  assign bsr_pin = {~qbus_hiz_ff, ball_s};
  assign bsr_sin = {tdi_s, bsr_shift[BSR_LEN-1:1]};

  for (genvar i = 0; i < BSR_LEN; i++) begin : g_cell
    scan_cell u_cell (
      .clk        (clk),
      .sys_rst    (sys_rst),
      .tap_rst    (in_reset),
      .capture_en (cap_dr && sel_bsr),
      .shift_en   (sh_dr && sel_bsr),
      .update_en  (upd_dr && sel_bsr),
      .pin_val    (bsr_pin[i]),
      .scan_in    (bsr_sin[i]),
      .shift_ff   (bsr_shift[i]),
      .upd_ff     (bsr_upd[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////
  // pin overrides toward the memory

  // cell 109 gates bus in external test
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ball_test_ff     <= '0;
      ball_test_sel_ff <= 1'b0;
      qbus_hiz_ff      <= 1'b0;
    end else begin
      ball_test_ff     <= bsr_upd[NUM_PINS-1:0];
      ball_test_sel_ff <= (ir_ff == INS_EXTEST);
      qbus_hiz_ff      <= (ir_ff == INS_SAMPLEZ) ||
                          ((ir_ff == INS_EXTEST) && !bsr_upd[BSR_OE_BIT]);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // serial output

  logic tdo_bit;

  always_comb begin
    if (state_ff == ST_SHIFT_IR) begin
      tdo_bit = ir_shift_ff[0];
    end else if (sel_bsr) begin
      tdo_bit = bsr_shift[0];
    end else if (sel_id) begin
      tdo_bit = id_shift_ff[0];
    end else begin
      tdo_bit = bypass_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tap_out.tdo      <= 1'b0;
      tap_out.tdo_oe_n <= 1'b1;
    end else if (tck_fall) begin
      tap_out.tdo      <= tdo_bit;
      tap_out.tdo_oe_n <= !((state_ff == ST_SHIFT_IR) || (state_ff == ST_SHIFT_DR));
    end
  end

endmodule : sram_boundary_scan_tap

/* testbench/tap_ctl_model.sv */
// Purpose: behavioural external test controller driving the test pins
// Assumes: test clock of 170 ns, held low between steps
// Notes:   each step samples the serial output just before the rising edge
`timescale 1ns/1ns
module tap_ctl_model (
  // system clock
  input  wire logic               clk,
  // test pins
  output tap_pkg::tap_pins_t      tap_pins,
  input  wire tap_pkg::tap_out_t  tap_out
);
  import tap_pkg::*;

  initial tap_pins = '{tck: 1'b0, tms: 1'b1, tdi: 1'b1};

  task automatic step(input logic tms, input logic tdi, output logic tdo, output logic oe_n);
    @(posedge clk) #1;
    tap_pins.tms = tms;
    tap_pins.tdi = tdi;
    repeat (8) @(posedge clk);
    #1;
    // released pin has no pull: read the inverse so a stray sample stands out
    tdo  = tap_out.tdo_oe_n ? ~tap_out.tdo : tap_out.tdo;
    oe_n = tap_out.tdo_oe_n;
    tap_pins.tck = 1'b1;
    repeat (8) @(posedge clk);
    #1 tap_pins.tck = 1'b0;
  endtask : step
endmodule : tap_ctl_model

/* testbench/sram_boundary_scan_tap_asserts.sv */
// Purpose: timing and reset checks on the test port outputs
// Assumes: test clock pin far slower than clk
// Notes:   age counters hold cycles since test-clock pin edges; ones_ff counts mode-select-high rises
`timescale 1ns/1ns
module tap_checker (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          sys_rst,
  // test pins
  input  wire tap_pkg::tap_pins_t            tap_pins,
  input  wire tap_pkg::tap_out_t             tap_out,
  // ball ring
  input  wire logic [tap_pkg::NUM_PINS-1:0]  ball_in,
  input  wire logic [tap_pkg::NUM_PINS-1:0]  ball_test_ff,
  input  wire logic                          ball_test_sel_ff,
  input  wire logic                          qbus_hiz_ff
);
  import tap_pkg::*;
  logic       tck_q_ff;
  logic [3:0] fall_age_ff;
  logic [3:0] edge_age_ff;
  logic [2:0] ones_ff;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk) begin
    tck_q_ff <= tap_pins.tck;
  end
  always_ff @(posedge clk) begin
    if (sys_rst) fall_age_ff <= 4'hf;
    else if (tck_q_ff && !tap_pins.tck) fall_age_ff <= 4'h0;
    else if (fall_age_ff != 4'hf) fall_age_ff <= fall_age_ff + 4'h1;
  end
  always_ff @(posedge clk) begin
    if (sys_rst) edge_age_ff <= 4'hf;
    else if (tck_q_ff != tap_pins.tck) edge_age_ff <= 4'h0;
    else if (edge_age_ff != 4'hf) edge_age_ff <= edge_age_ff + 4'h1;
  end
  // counts consecutive test-clock rises with mode-select high
  always_ff @(posedge clk) begin
    if (sys_rst) ones_ff <= 3'h0;
    else if (!tck_q_ff && tap_pins.tck)
      ones_ff <= !tap_pins.tms ? 3'h0 : (ones_ff == 3'h5) ? 3'h5 : ones_ff + 3'h1;
  end
  ////////////////////////////////////////////////////////////////////////////
  a_tdo_on_fall: assert property (
    $changed(tap_out.tdo) |-> !tap_pins.tck && fall_age_ff < 4'h7) else $error("tdo moved off fall");
  a_oe_on_fall: assert property (
    $changed(tap_out.tdo_oe_n) |-> !tap_pins.tck && fall_age_ff < 4'h7) else $error("oe moved off fall");
  a_oe_min_window: assert property (
    $fell(tap_out.tdo_oe_n) |=> !tap_out.tdo_oe_n [*8]) else $error("shift window too short");
  a_sel_after_edge: assert property (
    $changed(ball_test_sel_ff) |-> edge_age_ff < 4'h7) else $error("select moved without tck");
  a_hiz_after_edge: assert property (
    $changed(qbus_hiz_ff) |-> edge_age_ff < 4'h7) else $error("float moved without tck");
  a_drive_after_edge: assert property (
    $changed(ball_test_ff) |-> edge_age_ff < 4'h7) else $error("pin drive moved without tck");
  a_reset_quiet: assert property (
    $fell(sys_rst) |-> tap_out.tdo_oe_n && !ball_test_sel_ff && !qbus_hiz_ff && ball_test_ff == '0)
    else $error("outputs not quiet after reset");
  a_tms_reset: assert property (
    $rose(ones_ff == 3'h5) |-> ##[1:12] (tap_out.tdo_oe_n && !ball_test_sel_ff && !qbus_hiz_ff))
    else $error("five tms highs did not reset");
endmodule : tap_checker

bind sram_boundary_scan_tap tap_checker tap_checker_inst (
  .clk(clk), .sys_rst(sys_rst), .tap_pins(tap_pins), .tap_out(tap_out), .ball_in(ball_in),
  .ball_test_ff(ball_test_ff), .ball_test_sel_ff(ball_test_sel_ff), .qbus_hiz_ff(qbus_hiz_ff)
);

/* testbench/sram_boundary_scan_tap_test.sv */
// Purpose: self-checking bench for the boundary-scan test port
// Assumes: controller model steps the test clock at 170 ns
// Notes:   registers shift lsb first; expectations from package constants
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin n_errors++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module sram_boundary_scan_tap_test;
  import tap_pkg::*;
  logic                 clk;
  logic                 sys_rst;
  tap_pins_t            tap_pins;
  tap_out_t             tap_out;
  logic [NUM_PINS-1:0]  ball_in;
  logic [NUM_PINS-1:0]  ball_test_ff;
  logic                 ball_test_sel_ff;
  logic                 qbus_hiz_ff;
  logic                 tdo_b;
  logic                 oe_b;
  logic [127:0]         dout;
  int                   n_errors = 0;
  int                   n_checks = 0;

  sram_boundary_scan_tap sram_boundary_scan_tap_inst (.clk(clk), .sys_rst(sys_rst),
    .tap_pins(tap_pins), .tap_out(tap_out), .ball_in(ball_in), .ball_test_ff(ball_test_ff),
    .ball_test_sel_ff(ball_test_sel_ff), .qbus_hiz_ff(qbus_hiz_ff));
  tap_ctl_model tap_ctl_model_inst (.clk(clk), .tap_pins(tap_pins), .tap_out(tap_out));
  ////////////////////////////////////////////////////////////////////////////
  task automatic stp(input logic tms, input logic tdi = 1'b1);
    tap_ctl_model_inst.step(tms, tdi, tdo_b, oe_b);
  endtask : stp
  task automatic shift(input int n, input logic [127:0] din);
    for (int i = 0; i < n; i++) begin
      stp(i == n - 1, din[i]);
      dout[i] = tdo_b;
      `CHK(oe_b, 1'b0)
    end
    stp(1'b1);
    stp(1'b0);
  endtask : shift
  task automatic dr(input int n, input logic [127:0] din);
    stp(1'b1);
    stp(1'b0);
    stp(1'b0);
    shift(n, din);
  endtask : dr
  task automatic ir(input logic [2:0] code);
    // dr() adds the second select step, landing in the instruction column
    stp(1'b1);
    dr(3, {125'h0, code});
  endtask : ir
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset_id();
    repeat (5) stp(1'b1);
    stp(1'b0);
    `CHK(oe_b, 1'b1)
    `CHK(ball_test_sel_ff, 1'b0)
    `CHK({qbus_hiz_ff, ball_test_ff}, 110'h0)
    dr(32, 128'h0);
    `CHK(dout[31:0], ID_WORD)
    $display("done reset_id");
  endtask : t_reset_id
  task automatic t_ir_capture();
    ir(INS_SAMPLE);
    `CHK(dout[1:0], IR_CAPTURE)
    ir(INS_IDCODE);
    `CHK(dout[2:0], {1'b1, IR_CAPTURE})
    dr(32, 128'h0);
    `CHK(dout[31:0], ID_WORD)
    $display("done ir_capture");
  endtask : t_ir_capture
  task automatic t_bypass();
    logic [7:0] pats [2] = '{8'hdb, 8'ha4};
    ir(INS_BYPASS);
    foreach (pats[k]) begin
      dr(8, {120'h0, pats[k]});
      `CHK(dout[7:0], {pats[k][6:0], 1'b0})
    end
    $display("done bypass");
  endtask : t_bypass
  task automatic t_samplez();
    stp(1'b1);
    stp(1'b1);
    stp(1'b0);
    stp(1'b0);
    for (int i = 0; i < 3; i++) stp(i == 2, INS_SAMPLEZ[i]);
    `CHK(qbus_hiz_ff, 1'b0)
    stp(1'b1);
    stp(1'b0);
    `CHK(qbus_hiz_ff, 1'b1)
    dr(110, 128'h0);
    `CHK(dout[109:0], {1'b0, ball_in})
    ir(INS_IDCODE);
    `CHK(qbus_hiz_ff, 1'b0)
    $display("done samplez");
  endtask : t_samplez
  task automatic t_preload();
    ball_in = {4'h5, {15{7'h4d}}};
    ir(INS_SAMPLE);
    dr(110, {18'h0, ~{1'b0, ball_in}});
    `CHK(dout[109:0], {1'b1, ball_in})
    `CHK(ball_test_sel_ff, 1'b0)
    ir(INS_EXTEST);
    `CHK(ball_test_sel_ff, 1'b1)
    `CHK(ball_test_ff, ~ball_in)
    `CHK(qbus_hiz_ff, 1'b0)
    dr(110, {18'h0, 1'b0, ball_in});
    `CHK(dout[109:0], {1'b1, ball_in})
    `CHK(qbus_hiz_ff, 1'b1)
    `CHK(ball_test_ff, ball_in)
    $display("done preload");
  endtask : t_preload
  task automatic summarize();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    #200000;
    n_errors++;
    summarize();
  end
  initial begin
    sys_rst = 1'b1;
    ball_in = {4'ha, {15{7'h32}}};
    repeat (16) @(posedge clk);
    #1 sys_rst = 1'b0;
    repeat (3) @(posedge clk);
    t_reset_id();
    t_ir_capture();
    t_bypass();
    t_samplez();
    t_preload();
    t_reset_id();
    summarize();
  end
endmodule : sram_boundary_scan_tap_test
